// ---- hdl/byte_bit_pkg.sv ----
// Shared constants for the byte and bit instruction core.
// Assumes a twelve-bit instruction word and a 32-entry file space.
package byte_bit_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int         QUARTERS    = 4;
	localparam logic [1:0] QCNT_LAST   = 2'h3;
	localparam logic [1:0] QCNT_PRE    = 2'h2;

	// ****************************************
	// File addresses and flag positions
	// ****************************************
	localparam logic [4:0] TMR_ADDR    = 5'h01;
	localparam logic [4:0] PCL_ADDR    = 5'h02;
	localparam logic [4:0] STAT_ADDR   = 5'h03;
	localparam logic [4:0] PORT_ADDR   = 5'h06;
	localparam int         C_POS       = 0;
	localparam int         DCY_POS     = 1;
	localparam int         Z_POS       = 2;

	// ****************************************
	// Opcode patterns
	// ****************************************
	localparam logic [5:0] OPC_ADD_FILE = 6'h07;
	localparam logic [5:0] OPC_AND_FILE = 6'h05;
	localparam logic [3:0] OPC_BCLR    = 4'h4;
	localparam logic [3:0] OPC_BSET    = 4'h5;
	localparam logic [3:0] OPC_TSC     = 4'h6;
	localparam logic [3:0] OPC_TSS     = 4'h7;
	localparam logic [3:0] OPC_AND_LIT = 4'hE;
	localparam logic [2:0] OPC_BRANCH  = 3'h5;
	localparam logic [8:0] OPC_DIRLD   = 9'h000;
	localparam logic [2:0] DIRLD_PORT  = 3'h6;

	typedef enum logic [2:0] {
		ALU_ADD,
		ALU_AND,
		ALU_CLR_BIT,
		ALU_SET_BIT,
		ALU_PASS
	} alu_op_e;
endpackage

// ---- hdl/alu_if.sv ----
// Operand and result bundle between the core and its arithmetic unit.
// Assumes a purely combinational unit on the far side.
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
	import byte_bit_pkg::*;
	logic [7:0] w_val;
	logic [7:0] f_val;
	logic [2:0] bit_sel;
	alu_op_e    op;
	logic [7:0] result;
	logic       carry;
	logic       digit_carry;
	logic       zero;
	modport core (output w_val, f_val, bit_sel, op, input result, carry, digit_carry, zero);
	modport unit (input w_val, f_val, bit_sel, op, output result, carry, digit_carry, zero);
endinterface
`default_nettype wire

// ---- hdl/byte_alu.sv ----
// Combinational arithmetic unit for add, AND and single-bit edits.
// Assumes operands are stable for the whole instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module byte_alu
(
	alu_if.unit bus
);
	import byte_bit_pkg::*;
	logic [8:0] sum9;
	logic [4:0] nib5;

	always_comb
	begin
		sum9 = {1'b0, bus.w_val} + {1'b0, bus.f_val};
		nib5 = {1'b0, bus.w_val[3:0]} + {1'b0, bus.f_val[3:0]};
		bus.carry = sum9[8];
		bus.digit_carry = nib5[4];
		case (bus.op)
			ALU_ADD:     bus.result = sum9[7:0];
			ALU_AND:     bus.result = bus.w_val & bus.f_val;
			ALU_CLR_BIT: bus.result = bus.f_val & ~(8'h01 << bus.bit_sel);
			ALU_SET_BIT: bus.result = bus.f_val | (8'h01 << bus.bit_sel);
			default:     bus.result = bus.f_val;
		endcase
		bus.zero = (bus.result == 8'h00);
	end
endmodule // byte_alu
`default_nettype wire

// ---- hdl/byte_bit_core.sv ----
// Instruction core executing add, AND, bit edit, bit test and direction load.
// Assumes program memory answers the fetch address within one instruction cycle.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - PC writes except branch clear bit 8
// - Port self-modify reads pin levels
// - Direction load op 6 copies W
// - Timer-target writes clear assigned prescaler
// - Dest bit 0 to W, 1 to file
// - Add updates carry, digit carry, zero
// - Bit clear zeroes bit, flags kept
// - Bit set ones bit, flags kept
// - AND literal into W, zero only
// - AND W with file, zero only
// - Skip next when tested bit clear
// - Skip next when tested bit set
// - Skipped word replaced by no-op
// - Four clocks per instruction cycle
// - Bit ops decode top four bits
module byte_bit_core
(
	input  wire logic       mclk_in,
	input  wire logic       nrst_in,
	input  wire logic [11:0] instr_in,
	input  wire logic [7:0] pins_in,
	input  wire logic       psa_tmr_in,
	output logic      [8:0] pc_out,
	output logic      [7:0] w_out,
	output logic      [2:0] flags_out,
	output logic      [7:0] port_out,
	output logic      [7:0] port_oe_out,
	output logic      [7:0] tmr_out,
	output logic            presc_clr_out,
	output logic            cycle_en_out
);
	import byte_bit_pkg::*;

	typedef struct packed {
		logic [1:0]  qcnt;
		logic        cyc_en;
		logic [8:0]  pc;
		logic [11:0] ir;
		logic        flush;
		logic [7:0]  w;
		logic [2:0]  flags;
		logic [7:0]  port_lat;
		logic [7:0]  drive_en;
		logic [7:0]  tmr;
		logic        presc_clr;
	} state_s;

	state_s     st_q;
	state_s     st_d;
	logic [7:0] ram [32];
	logic [4:0] f_addr;
	logic       dest_f;
	logic [2:0] bsel;
	logic [7:0] rd;
	logic       en;
	logic       is_add;
	logic       is_and_file;
	logic       is_bclr;
	logic       is_bset;
	logic       is_tsc;
	logic       is_tss;
	logic       is_and_lit;
	logic       is_branch;
	logic       is_dirld;
	logic       wr_file;
	logic       wr_w;
	logic       skip;
	logic       pcl_wr;

	alu_if alu ();

	byte_alu u_alu
	(
		.bus (alu.unit)
	);

	// ****************************************
	// Decode
	// ****************************************
	always_comb
	begin
		en        = st_q.cyc_en;
		f_addr    = st_q.ir[4:0];
		dest_f    = st_q.ir[5];
		bsel      = st_q.ir[7:5];
		is_add    = !st_q.flush && st_q.ir[11:6] == OPC_ADD_FILE;
		is_and_file = !st_q.flush && st_q.ir[11:6] == OPC_AND_FILE;
		is_bclr   = !st_q.flush && st_q.ir[11:8] == OPC_BCLR;
		is_bset   = !st_q.flush && st_q.ir[11:8] == OPC_BSET;
		is_tsc    = !st_q.flush && st_q.ir[11:8] == OPC_TSC;
		is_tss    = !st_q.flush && st_q.ir[11:8] == OPC_TSS;
		is_and_lit = !st_q.flush && st_q.ir[11:8] == OPC_AND_LIT;
		is_branch = !st_q.flush && st_q.ir[11:9] == OPC_BRANCH;
		is_dirld  = !st_q.flush && st_q.ir[11:3] == OPC_DIRLD
			&& st_q.ir[2:0] == DIRLD_PORT;
		// Port reads see the pins, not the latch
		case (f_addr)
			TMR_ADDR:  rd = st_q.tmr;
			PCL_ADDR:  rd = st_q.pc[7:0];
			STAT_ADDR: rd = {5'h00, st_q.flags};
			PORT_ADDR: rd = pins_in;
			default:   rd = ram[f_addr];
		endcase
		alu.w_val   = st_q.w;
		alu.f_val   = is_and_lit ? st_q.ir[7:0] : rd;
		alu.bit_sel = bsel;
		if (is_add)
			alu.op = ALU_ADD;
		else if (is_and_file || is_and_lit)
			alu.op = ALU_AND;
		else if (is_bclr)
			alu.op = ALU_CLR_BIT;
		else if (is_bset)
			alu.op = ALU_SET_BIT;
		else
			alu.op = ALU_PASS;
		wr_file = ((is_add || is_and_file) && dest_f) || is_bclr || is_bset;
		wr_w    = ((is_add || is_and_file) && !dest_f) || is_and_lit;
		skip    = (is_tsc && !rd[bsel]) || (is_tss && rd[bsel]);
		pcl_wr  = wr_file && f_addr == PCL_ADDR;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		st_d.qcnt = st_q.qcnt + 2'h1;
		st_d.cyc_en = (st_q.qcnt == QCNT_PRE);
		st_d.presc_clr = 1'b0;
		if (en)
		begin
			st_d.ir = instr_in;
			st_d.pc = st_q.pc + 9'h001;
			st_d.flush = skip || is_branch || pcl_wr;
			if (is_branch)
				st_d.pc = st_q.ir[8:0];
			if (wr_w)
				st_d.w = alu.result;
			if (wr_file)
			begin
				case (f_addr)
					TMR_ADDR:  st_d.tmr = alu.result;
					PCL_ADDR:  st_d.pc = {1'b0, alu.result};
					STAT_ADDR: st_d.flags = alu.result[2:0];
					PORT_ADDR: st_d.port_lat = alu.result;
					default:   st_d.flags = st_q.flags;
				endcase
			end
			if (wr_file && f_addr == TMR_ADDR && psa_tmr_in)
				st_d.presc_clr = 1'b1;
			if (is_add)
			begin
				st_d.flags[C_POS] = alu.carry;
				st_d.flags[DCY_POS] = alu.digit_carry;
			end
			if (is_add || is_and_file || is_and_lit)
				st_d.flags[Z_POS] = alu.zero;
			if (is_dirld)
				st_d.drive_en = ~st_q.w;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// General-purpose file locations, cleared at reset
	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in)
		begin
			for (int i = 0; i < 32; i++)
				ram[i] <= 8'h00;
		end
		else if (en && wr_file && f_addr > PORT_ADDR)
			ram[f_addr] <= alu.result;
	end

	always_comb
	begin
		pc_out        = st_q.pc;
		w_out         = st_q.w;
		flags_out     = st_q.flags;
		port_out      = st_q.port_lat;
		port_oe_out   = st_q.drive_en;
		tmr_out       = st_q.tmr;
		presc_clr_out = st_q.presc_clr;
		cycle_en_out  = st_q.cyc_en;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);

	cycle_period_a: assert property (en |=> !en [*3] ##1 en)
		else $error("instruction cycle not four clocks");
	pcl_bit8_a: assert property (en && pcl_wr |=> !st_q.pc[8])
		else $error("pc bit 8 not cleared");
	port_pins_a: assert property (en && is_and_file && dest_f && f_addr == PORT_ADDR
		|=> st_q.port_lat == ($past(pins_in) & $past(st_q.w)))
		else $error("port write did not use pins");
	dirld_copy_a: assert property (en && is_dirld |=> st_q.drive_en == ~$past(st_q.w))
		else $error("direction latches not loaded");
	presc_clear_a: assert property (en && wr_file && f_addr == TMR_ADDR && psa_tmr_in
		|=> presc_clr_out ##1 !presc_clr_out)
		else $error("prescaler clear missing");
	add_dest_a: assert property (en && is_add && !dest_f
		|=> {st_q.flags[C_POS], st_q.w} == ({1'b0, $past(st_q.w)} + {1'b0, $past(rd)}))
		else $error("add result or carry wrong");
	bit_flags_a: assert property (en && (is_bclr || is_bset) && f_addr != STAT_ADDR
		|=> $stable(st_q.flags))
		else $error("bit edit changed flags");
	bclr_port_a: assert property (en && is_bclr && f_addr == PORT_ADDR
		|=> !st_q.port_lat[$past(bsel)])
		else $error("bit clear failed on port");
	and_lit_a: assert property (en && is_and_lit
		|=> st_q.w == ($past(st_q.w) & $past(st_q.ir[7:0]))
		&& st_q.flags[Z_POS] == (st_q.w == 8'h00))
		else $error("and literal wrong");
	skip_nop_a: assert property (en && skip |=> st_q.flush ##4 !st_q.flush)
		else $error("skipped word not discarded");
endmodule // byte_bit_core
`default_nettype wire

// ---- hdl/placeholder_none.sv ----
// Intentionally empty compile unit.

// ---- sim/prog_mem.sv ----
// Program memory model for the core's fetch port.
// Assumes the bench fills mem before reset is released.
`timescale 1ns/1ps
`default_nettype none
module prog_mem
(
	input  wire logic [8:0]  addr_in,
	output logic      [11:0] word_out
);
	logic [11:0] mem [0:511];
	// Answers at once, well inside one cycle
	assign word_out = mem[addr_in];
endmodule // prog_mem
`default_nettype wire

// ---- sim/testbench.sv ----
// Random program run on byte_bit_core, checked against a model.
// Assumes prog_mem as fetch source; pins and prescaler owner random.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import byte_bit_pkg::*;
	localparam int NUM = 600;
	logic        mclk_in;
	logic        nrst_in;
	logic [11:0] instr;
	logic [7:0]  pins, w_o, port_o, oe_o, tmr_o;
	logic        psa, presc_o, cyc_o;
	logic [2:0]  flags_o;
	logic [8:0]  pc;
	logic [16:0] rnd = 17'h17817;
	int          num_errors, checks, cyc, gap, pcnt, cnt;
	logic [7:0]  w_x, port_x, dir_x, tmr_x;
	logic [7:0]  ram_x [0:31];
	logic [2:0]  fl_x;
	logic [8:0]  pc_x;
	logic [11:0] ir_x;
	logic        presc_x;
	logic        pcl_hit;
	logic [7:0]  pcl_v;
	// ****************************************
	// Helpers and model
	// ****************************************
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	function automatic logic [11:0] pick(input logic [16:0] v);
		logic [4:0] f;
		f = v[4:0];
		if (f != TMR_ADDR && f != PCL_ADDR && f < PORT_ADDR)
			f = f + 5'h08;
		case (v[16:14])
			3'h0: return {OPC_ADD_FILE, v[5], f};
			3'h1: return {OPC_AND_FILE, v[5], f};
			3'h2, 3'h3: return {2'h1, 1'b0, v[6], v[9:7], f};
			3'h4: return {2'h1, 1'b1, v[6], v[9:7], f};
			3'h5: return {OPC_AND_LIT, v[13:6]};
			3'h6: return {OPC_DIRLD, v[7] ? DIRLD_PORT : v[10:8]};
			default: return {OPC_BRANCH, v[13:5]};
		endcase
	endfunction
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("num_errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic put(input logic [4:0] f, input logic [7:0] r);
		if (f == TMR_ADDR)
		begin
			tmr_x = r;
			presc_x = psa;
		end
		else if (f == PCL_ADDR)
		begin
			pcl_hit = 1'b1;
			pcl_v = r;
		end
		else if (f == PORT_ADDR)
			port_x = r;
		else if (f > PORT_ADDR)
			ram_x[f] = r;
	endtask
	task automatic step;
		logic [11:0] i;
		logic [7:0]  v;
		logic [8:0]  s;
		logic        sk;
		i = ir_x;
		sk = 1'b0;
		presc_x = 1'b0;
		pcl_hit = 1'b0;
		case (i[4:0])
			PORT_ADDR: v = pins;
			TMR_ADDR:  v = tmr_x;
			PCL_ADDR:  v = pc_x[7:0];
			default:   v = ram_x[i[4:0]];
		endcase
		if (i[11:6] == OPC_ADD_FILE || i[11:6] == OPC_AND_FILE)
		begin
			s = i[7] ? {1'b0, w_x} + {1'b0, v} : {1'b0, w_x & v};
			if (i[7])
				fl_x[1:0] = {({1'b0, w_x[3:0]} + {1'b0, v[3:0]}) > 5'h0F, s[8]};
			fl_x[Z_POS] = (s[7:0] == 8'h00);
			if (i[5])
				put(i[4:0], s[7:0]);
			else
				w_x = s[7:0];
		end
		else if (i[11:10] == 2'h1 && !i[9])
		begin
			v[i[7:5]] = i[8];
			put(i[4:0], v);
		end
		else if (i[11:10] == 2'h1)
			sk = (v[i[7:5]] == i[8]);
		else if (i[11:8] == OPC_AND_LIT)
		begin
			w_x = w_x & i[7:0];
			fl_x[Z_POS] = (w_x == 8'h00);
		end
		else if (i[11:3] == OPC_DIRLD && i[2:0] == DIRLD_PORT)
			dir_x = w_x;
		sk = sk || pcl_hit || (i[11:9] == OPC_BRANCH);
		ir_x = sk ? 12'h000 : mem_u.mem[pc_x];
		if (pcl_hit)
			pc_x = {1'b0, pcl_v};
		else
			pc_x = (i[11:9] == OPC_BRANCH) ? i[8:0] : pc_x + 9'h001;
	endtask
	// ****************************************
	// Instances and stimulus
	// ****************************************
	prog_mem mem_u (.addr_in(pc), .word_out(instr));
	byte_bit_core dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .instr_in(instr),
		.pins_in(pins), .psa_tmr_in(psa), .pc_out(pc), .w_out(w_o), .flags_out(flags_o),
		.port_out(port_o), .port_oe_out(oe_o), .tmr_out(tmr_o), .presc_clr_out(presc_o),
		.cycle_en_out(cyc_o));
	initial
	begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end
	initial
	begin
		logic [16:0] seed;
		{nrst_in, w_x, port_x, tmr_x, fl_x, pc_x, ir_x, presc_x} = '0;
		dir_x = 8'hFF;
		seed = 17'h17817;
		for (int a = 0; a < 512; a++)
		begin
			repeat (7) seed = lfsr(seed);
			mem_u.mem[a] = pick(seed);
			ram_x[a[4:0]] = 8'h00;
		end
		repeat (12) @(posedge mclk_in);
		nrst_in <= 1'b1;
	end
	always @(posedge mclk_in)
	begin
		rnd <= lfsr(rnd);
		pins <= rnd[7:0];
		psa <= rnd[9];
		cyc++;
		if (cyc > NUM * 4 + 200)
		begin
			num_errors++;
			complete_run;
		end
		else if (nrst_in === 1'b1)
		begin
			gap++;
			pcnt += (presc_o === 1'b1);
			if (cyc_o === 1'b1)
			begin
				if (cnt > 0)
					chk(9'(gap), 9'(QUARTERS));
				chk(pc, pc_x);
				chk(9'(w_o), 9'(w_x));
				chk(9'(flags_o), 9'(fl_x));
				chk(9'(port_o), 9'(port_x));
				chk({1'b0, oe_o}, {1'b0, ~dir_x});
				chk(9'(tmr_o), 9'(tmr_x));
				chk(9'(pcnt), 9'(presc_x));
				step;
				gap = 0;
				pcnt = 0;
				cnt++;
				if (cnt > NUM)
					complete_run;
			end
		end
	end
endmodule // testbench
`default_nettype wire
